// ### cpx_sequencer.sv
/*
 * Processor-side sequencer for coprocessor instructions: offer,
 * busy-wait, data transfers, register transfers and undefined trap.
 * Assumes coprocessor inputs synchronous to core_clk; words loaded
 * from the coprocessor leave through a 16-word FIFO.
 */
`timescale 1ns/10ps
module cpx_sequencer (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // instruction request
    input wire logic start_valid,
    output logic start_ready,
    input wire cpx_pkg::cpx_op_type start_op,
    input wire logic [31:0] start_pc,
    input wire logic [31:0] start_base,
    input wire logic [31:0] start_reg_word,
    // coprocessor handshake
    input wire logic coproc_absent,
    input wire logic coproc_busy,
    input wire logic [31:0] coproc_word,
    output logic coproc_instr_strobe_n,
    // memory bus
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic mem_request_n,
    output logic burst_continue,
    output logic instr_fetch_n,
    output logic write_not_read,
    output logic byte_word_n,
    // results
    output logic undef_trap,
    output logic done,
    // register write-back stream
    output logic rf_valid,
    input wire logic rf_ready,
    output logic [31:0] rf_word
);
    // ==========================================================
    // state
    cpx_pkg::cpx_state_type state_q, state_d;
    cpx_pkg::cpx_op_type op_q, op_d;
    logic [31:0] addr_q, addr_d, pc_q, pc_d, wdata_q, wdata_d, cap_q, cap_d;
    logic first_q, first_d;
    logic [31:0] start_base_q, start_base_d;
    logic refuse, commit;

    cpx_stream_if #(.W(cpx_pkg::WORD_W)) push_if ();
    cpx_stream_if #(.W(cpx_pkg::WORD_W)) pop_if ();

    function automatic logic is_data_xfer(input cpx_pkg::cpx_op_type op);
        return (op == cpx_pkg::OP_MEM_TO_CP) || (op == cpx_pkg::OP_CP_TO_MEM);
    endfunction

    // both lines high means the offer is refused
    assign refuse = coproc_absent && coproc_busy;
    assign commit = !coproc_busy;
    assign start_ready = (state_q == cpx_pkg::ST_IDLE) && push_if.ready;

    // ==========================================================
    // next state
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        addr_d = addr_q;
        pc_d = pc_q;
        wdata_d = wdata_q;
        cap_d = cap_q;
        first_d = 1'b0;
        case (state_q)
            cpx_pkg::ST_IDLE: begin
                if (start_valid && start_ready) begin
                    state_d = cpx_pkg::ST_OFFER;
                    op_d = start_op;
                    pc_d = start_pc;
                    addr_d = start_pc + cpx_pkg::PC_OFFER_OFS;
                    wdata_d = start_reg_word;
                    first_d = 1'b1;
                end
            end
            cpx_pkg::ST_OFFER: begin
                if (refuse) begin
                    state_d = cpx_pkg::ST_TRAP;
                end else if (commit) begin
                    if (is_data_xfer(op_q)) begin
                        state_d = cpx_pkg::ST_XFER;
                        addr_d = start_base_q;
                    end else if (op_q == cpx_pkg::OP_CP_DATA) begin
                        state_d = cpx_pkg::ST_IDLE;
                        addr_d = pc_q + cpx_pkg::PC_NEXT_OFS;
                    end else begin
                        state_d = cpx_pkg::ST_REG2;
                        addr_d = pc_q + cpx_pkg::PC_NEXT_OFS;
                    end
                end
            end
            cpx_pkg::ST_XFER: begin
                if (refuse) begin
                    state_d = cpx_pkg::ST_IDLE;
                    addr_d = pc_q + cpx_pkg::PC_NEXT_OFS;
                end else begin
                    addr_d = addr_q + cpx_pkg::ADDR_STEP;
                end
            end
            cpx_pkg::ST_REG2: begin
                cap_d = coproc_word;
                // store ends after the second cycle
                state_d = (op_q == cpx_pkg::OP_CP_TO_REG) ? cpx_pkg::ST_REG3 : cpx_pkg::ST_IDLE;
            end
            cpx_pkg::ST_REG3: begin
                state_d = cpx_pkg::ST_IDLE;
            end
            cpx_pkg::ST_TRAP: begin
                state_d = cpx_pkg::ST_IDLE;
            end
            default: begin
                state_d = cpx_pkg::ST_IDLE;
            end
        endcase
    end

    assign start_base_d = (state_q == cpx_pkg::ST_IDLE && start_valid && start_ready) ? start_base : start_base_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= cpx_pkg::ST_IDLE;
            op_q <= cpx_pkg::OP_CP_DATA;
            addr_q <= cpx_pkg::ADDR_RESET;
            pc_q <= cpx_pkg::ADDR_RESET;
            wdata_q <= cpx_pkg::ADDR_RESET;
            cap_q <= cpx_pkg::ADDR_RESET;
            start_base_q <= cpx_pkg::ADDR_RESET;
            first_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            addr_q <= addr_d;
            pc_q <= pc_d;
            wdata_q <= wdata_d;
            cap_q <= cap_d;
            start_base_q <= start_base_d;
            first_q <= first_d;
        end
    end

    // ==========================================================
    // bus control lines
    assign mem_addr = addr_q;
    assign mem_wdata = wdata_q;
    assign byte_word_n = 1'b1;

    always_comb begin
        mem_request_n = 1'b1;
        burst_continue = 1'b0;
        instr_fetch_n = 1'b1;
        write_not_read = 1'b0;
        coproc_instr_strobe_n = 1'b1;
        undef_trap = 1'b0;
        done = 1'b0;
        case (state_q)
            cpx_pkg::ST_OFFER: begin
                // strobe low while offering and waiting
                coproc_instr_strobe_n = 1'b0;
                instr_fetch_n = !first_q;
                mem_request_n = coproc_busy;
                burst_continue = commit && is_data_xfer(op_q);
                done = commit && (op_q == cpx_pkg::OP_CP_DATA);
            end
            cpx_pkg::ST_XFER: begin
                mem_request_n = 1'b0;
                // sequential cycles until the last word
                burst_continue = !refuse;
                write_not_read = (op_q == cpx_pkg::OP_CP_TO_MEM);
                done = refuse;
            end
            cpx_pkg::ST_REG2: begin
                mem_request_n = (op_q == cpx_pkg::OP_CP_TO_REG);
                write_not_read = (op_q == cpx_pkg::OP_REG_TO_CP);
                done = (op_q == cpx_pkg::OP_REG_TO_CP);
            end
            cpx_pkg::ST_REG3: begin
                // write-back merged with the next fetch
                mem_request_n = 1'b0;
                done = 1'b1;
            end
            cpx_pkg::ST_TRAP: begin
                undef_trap = 1'b1;
                done = 1'b1;
            end
            default: begin
                mem_request_n = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // register write-back through the FIFO
    // destination word pushed in the third cycle
    assign push_if.valid = (state_q == cpx_pkg::ST_REG3);
    assign push_if.data = cap_q;
    assign rf_valid = pop_if.valid;
    assign rf_word = pop_if.data;
    assign pop_if.ready = rf_ready;

    cpx_fifo #(
        .W(cpx_pkg::WORD_W),
        .DEPTH(cpx_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .fill(push_if.sink),
        .drain(pop_if.source)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_trap_on_refuse: assert property (
        state_q == cpx_pkg::ST_OFFER && coproc_absent && coproc_busy |=> undef_trap && !coproc_instr_strobe_n == 1'b0)
        else $error("refused offer did not trap");
    a_wait_no_request: assert property (
        state_q == cpx_pkg::ST_OFFER && coproc_busy |-> mem_request_n && !coproc_instr_strobe_n)
        else $error("busy-wait issued a memory request");
    a_wait_addr_hold: assert property (
        state_q == cpx_pkg::ST_OFFER && coproc_busy && !coproc_absent |=> mem_addr == $past(mem_addr))
        else $error("busy-wait address moved");
    a_xfer_addr_step: assert property (
        state_q == cpx_pkg::ST_XFER && !(coproc_absent && coproc_busy)
        |=> mem_addr == $past(mem_addr) + cpx_pkg::ADDR_STEP)
        else $error("transfer address not sequential");
    a_xfer_direction: assert property (
        state_q == cpx_pkg::ST_XFER |-> write_not_read == (op_q == cpx_pkg::OP_CP_TO_MEM))
        else $error("transfer direction wrong");
    a_load_third_cycle: assert property (
        state_q == cpx_pkg::ST_REG2 && op_q == cpx_pkg::OP_CP_TO_REG
        |=> push_if.valid && push_if.data == $past(coproc_word) ##1 !push_if.valid)
        else $error("loaded word not written in third cycle");
    a_store_two_cycles: assert property (
        state_q == cpx_pkg::ST_REG2 && op_q == cpx_pkg::OP_REG_TO_CP |=> state_q == cpx_pkg::ST_IDLE)
        else $error("store ran a third cycle");
    a_strobe_release: assert property (
        state_q == cpx_pkg::ST_OFFER && (!coproc_busy || coproc_absent) |=> coproc_instr_strobe_n)
        else $error("strobe not raised after commit or trap");
    a_merged_ncycle: assert property (
        state_q == cpx_pkg::ST_REG3 |-> !mem_request_n && !burst_continue)
        else $error("merged cycle not nonsequential");

    c_trap: cover property (undef_trap);
    c_burst: cover property (state_q == cpx_pkg::ST_XFER ##1 state_q == cpx_pkg::ST_XFER ##1 done);
    c_load: cover property (push_if.valid);
    c_wait: cover property ((state_q == cpx_pkg::ST_OFFER && coproc_busy && !coproc_absent) [*3]);
endmodule

// ### cpx_pkg.sv
/*
 * Constants and types for the coprocessor transfer sequencer.
 * Assumes one 20 MHz core clock and a synchronous active-high reset.
 */
// Functional notes
// - coproc-to-memory as memory-to-coproc, but writing
// - register load moves one word, same wait
// - loaded word written in third cycle
// - third cycle merged as nonsequential memory cycle
// - register store omits the final cycle
// - absent and busy high means undefined trap
// - busy-wait repeats address, memory request high
// - not ready: absent low, busy high, wait
// - after commit, sequential word addresses each cycle
package cpx_pkg;
    // ==========================================================
    // widths and sizes
    localparam int WORD_W = 32;
    localparam int FIFO_DEPTH = 16;

    // ==========================================================
    // address offsets
    localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
    localparam logic [31:0] PC_OFFER_OFS = 32'h0000_0008;
    localparam logic [31:0] PC_NEXT_OFS = 32'h0000_000C;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

    // ==========================================================
    // operation kinds and sequencer states
    typedef enum logic [2:0] {
        OP_CP_DATA,
        OP_MEM_TO_CP,
        OP_CP_TO_MEM,
        OP_CP_TO_REG,
        OP_REG_TO_CP
    } cpx_op_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OFFER,
        ST_XFER,
        ST_REG2,
        ST_REG3,
        ST_TRAP
    } cpx_state_type;
endpackage

// ### cpx_stream_if.sv
/*
 * Valid/ready word stream between the sequencer and its buffer.
 * Assumes both ends share the core clock.
 */
`timescale 1ns/10ps
interface cpx_stream_if #(
    parameter int W = 32
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

// ### cpx_fifo.sv
/*
 * Word FIFO with valid/ready on both sides.
 * Assumes a synchronous active-high reset on core_clk.
 */
`timescale 1ns/10ps
module cpx_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // fill side
    cpx_stream_if.sink fill,
    // drain side
    cpx_stream_if.source drain
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign fill.ready = (cnt_q != (AW+1)'(DEPTH));
    assign drain.valid = (cnt_q != '0);
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    always_comb begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_q] <= fill.data;
        end
    end

    assign drain.data = mem[rd_q];
endmodule

// ### cpx_coproc_model.sv
/*
 * Coprocessor model for the transfer sequencer bench.
 * Assumes the bench sets wait, word count and refusal while idle.
 */
`timescale 1ns/10ps
module cpx_coproc_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // behaviour chosen by the bench
    input wire logic [3:0] wait_cycles,
    input wire logic [3:0] word_count,
    input wire logic refuse,
    input wire logic [31:0] word_base,
    // handshake
    input wire logic coproc_instr_strobe_n,
    output logic coproc_absent,
    output logic coproc_busy,
    output logic [31:0] coproc_word
);
    logic [3:0] offer_q, offer_d, idx_q, idx_d;
    logic xfer_q, xfer_d, commit;
    logic [31:0] tick_q;

    // ==========================================================
    // offer and transfer tracking
    always_comb begin
        commit = !coproc_instr_strobe_n && !xfer_q && !refuse && offer_q >= wait_cycles;
        offer_d = coproc_instr_strobe_n ? 4'h0 : offer_q + 4'h1;
        xfer_d = commit || (xfer_q && idx_q + 4'h1 < word_count);
        idx_d = commit ? 4'h0 : idx_q + 4'h1;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            offer_q <= 4'h0;
            idx_q <= 4'h0;
            xfer_q <= 1'h0;
            tick_q <= 32'h0;
        end else begin
            offer_q <= offer_d;
            idx_q <= idx_d;
            xfer_q <= xfer_d;
            tick_q <= tick_q + 32'h1;
        end
    end

    // ==========================================================
    // handshake outputs
    always_comb begin
        coproc_word = ~tick_q;
        if (xfer_q) begin
            {coproc_absent, coproc_busy} = (idx_q + 4'h1 >= word_count) ? 2'h3 : 2'h0;
            coproc_word = word_base + {26'h0, idx_q, 2'h0};
        end else if (!coproc_instr_strobe_n && !refuse) begin
            {coproc_absent, coproc_busy} = (offer_q < wait_cycles) ? 2'h1 : 2'h0;
        end else begin
            {coproc_absent, coproc_busy} = 2'h3;
        end
    end
endmodule

// ### coproc_transfer_handshake_test.sv
/*
 * Bench for the coprocessor transfer sequencer.
 * Assumes the coprocessor model on the far side.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module coproc_transfer_handshake_test;
    logic core_clk = 1'h0, rst = 1'h1, start_valid = 1'h0, rf_ready = 1'h0, refuse = 1'h0;
    cpx_pkg::cpx_op_type start_op = cpx_pkg::OP_CP_DATA;
    logic [31:0] start_pc = 32'h0, start_base = 32'h0, start_reg_word = 32'h0, word_base = 32'h0;
    logic [3:0] wait_cycles = 4'h0, word_count = 4'h1;
    logic [31:0] coproc_word, mem_addr, mem_wdata, rf_word;
    logic start_ready, coproc_absent, coproc_busy, strobe_n, mem_request_n, burst_continue;
    logic instr_fetch_n, write_not_read, byte_word_n, undef_trap, done, rf_valid;
    int miscompares = 0, check_count = 0, cycles = 0;

    cpx_sequencer i_cpx_sequencer (.core_clk(core_clk), .rst(rst), .start_valid(start_valid),
        .start_ready(start_ready), .start_op(start_op), .start_pc(start_pc), .start_base(start_base),
        .start_reg_word(start_reg_word), .coproc_absent(coproc_absent), .coproc_busy(coproc_busy),
        .coproc_word(coproc_word), .coproc_instr_strobe_n(strobe_n), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_request_n(mem_request_n), .burst_continue(burst_continue),
        .instr_fetch_n(instr_fetch_n), .write_not_read(write_not_read), .byte_word_n(byte_word_n),
        .undef_trap(undef_trap), .done(done), .rf_valid(rf_valid), .rf_ready(rf_ready),
        .rf_word(rf_word));
    cpx_coproc_model i_cpx_coproc_model (.core_clk(core_clk), .rst(rst), .wait_cycles(wait_cycles),
        .word_count(word_count), .refuse(refuse), .word_base(word_base),
        .coproc_instr_strobe_n(strobe_n), .coproc_absent(coproc_absent), .coproc_busy(coproc_busy),
        .coproc_word(coproc_word));

    // ==========================================================
    // clock, hang guard and verdict
    always #25 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // shared steps
    task automatic tick();
        @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // returns in the first offer cycle
    task automatic issue(input cpx_pkg::cpx_op_type op, input logic [31:0] pc, input logic [3:0] w,
                         input logic [3:0] n);
        start_op = op;
        start_pc = pc;
        start_valid = 1'h1;
        while (start_ready !== 1'h1) @(negedge core_clk);
        // model settings change only once the previous transfer is over
        wait_cycles = w;
        word_count = n;
        tick();
        start_valid = 1'h0;
    endtask

    // returns in the commit cycle
    task automatic offer(input logic [31:0] pc, input logic [3:0] w);
        for (int i = 0; i <= w; i++) begin
            if (i > 0) tick();
            `CHK("addr_offer", pc + 32'h8, mem_addr)
            `CHK("strobe_offer", 1'h0, strobe_n)
            `CHK("mreq_offer", i < w, mem_request_n)
            `CHK("fetch_offer", i > 0, instr_fetch_n)
            `CHK("rw_offer", 1'h0, write_not_read)
        end
    endtask

    task automatic load_word(input logic [31:0] pc, input logic [3:0] w, input logic [31:0] word);
        word_base = word;
        issue(cpx_pkg::OP_CP_TO_REG, pc, w, 4'h1);
        offer(pc, w);
        tick();
        `CHK("addr_ld2", pc + 32'hC, mem_addr)
        `CHK("mreq_ld2", 1'h1, mem_request_n)
        `CHK("strobe_ld2", 1'h1, strobe_n)
        tick();
        `CHK("mreq_ld3", 1'h0, mem_request_n)
        `CHK("seq_ld3", 1'h0, burst_continue)
        `CHK("done_ld3", 1'h1, done)
    endtask

    // ==========================================================
    // scenarios
    task automatic fill_and_drain();
        for (int i = 0; i < cpx_pkg::FIFO_DEPTH; i++) begin
            load_word(32'h100 + 32'(i * 16), 4'(i % 3), 32'hC0DE_0000 + 32'(i));
        end
        start_valid = 1'h1;
        repeat (3) begin
            tick();
            `CHK("ready_full", 1'h0, start_ready)
            `CHK("strobe_full", 1'h1, strobe_n)
        end
        start_valid = 1'h0;
        rf_ready = 1'h1;
        for (int i = 0; i < cpx_pkg::FIFO_DEPTH; i++) begin
            `CHK("rf_valid", 1'h1, rf_valid)
            `CHK("rf_word", 32'hC0DE_0000 + 32'(i), rf_word)
            tick();
        end
        `CHK("rf_empty", 1'h0, rf_valid)
        rf_ready = 1'h0;
    endtask

    task automatic store_word();
        start_reg_word = 32'h5A5A_0F0F;
        issue(cpx_pkg::OP_REG_TO_CP, 32'h200, 4'h2, 4'h1);
        offer(32'h200, 4'h2);
        tick();
        `CHK("rw_st", 1'h1, write_not_read)
        `CHK("wdata_st", 32'h5A5A_0F0F, mem_wdata)
        `CHK("mreq_st", 1'h0, mem_request_n)
        `CHK("done_st", 1'h1, done)
        tick();
        `CHK("end_st", 1'h0, done)
    endtask

    task automatic data_xfer(input cpx_pkg::cpx_op_type op, input logic [3:0] w, input logic [3:0] n);
        start_base = 32'h4000;
        issue(op, 32'h300, w, n);
        offer(32'h300, w);
        for (int i = 0; i < n; i++) begin
            tick();
            `CHK("addr_dx", 32'h4000 + 32'(i * 4), mem_addr)
            `CHK("mreq_dx", 1'h0, mem_request_n)
            `CHK("seq_dx", i < n - 1, burst_continue)
            `CHK("rw_dx", op == cpx_pkg::OP_CP_TO_MEM, write_not_read)
            `CHK("done_dx", i == n - 1, done)
        end
    endtask

    task automatic data_op();
        issue(cpx_pkg::OP_CP_DATA, 32'h400, 4'h3, 4'h1);
        offer(32'h400, 4'h3);
        `CHK("done_op", 1'h1, done)
        tick();
        `CHK("strobe_op", 1'h1, strobe_n)
    endtask

    task automatic trap();
        refuse = 1'h1;
        issue(cpx_pkg::OP_CP_TO_REG, 32'h500, 4'h0, 4'h1);
        `CHK("strobe_tr1", 1'h0, strobe_n)
        `CHK("undef_tr1", 1'h0, undef_trap)
        tick();
        `CHK("undef_tr", 1'h1, undef_trap)
        `CHK("done_tr", 1'h1, done)
        `CHK("strobe_tr", 1'h1, strobe_n)
        tick();
        `CHK("once_tr", 1'h0, undef_trap)
        refuse = 1'h0;
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'h0;
        `CHK("strobe_idle", 1'h1, strobe_n)
        `CHK("bw_idle", 1'h1, byte_word_n)
        fill_and_drain();
        store_word();
        data_xfer(cpx_pkg::OP_MEM_TO_CP, 4'h0, 4'h3);
        data_xfer(cpx_pkg::OP_CP_TO_MEM, 4'h2, 4'h4);
        data_xfer(cpx_pkg::OP_CP_TO_MEM, 4'h0, 4'h1);
        data_op();
        trap();
        tally_and_finish();
    end
endmodule
